//--- shared/oad_defs.svh
`ifndef OAD_DEFS_SVH
`define OAD_DEFS_SVH

// ****************************************
// prefix byte values
// ****************************************
`define OAD_PFX_Y 8'h90
`define OAD_PFX_IDY 8'h91
`define OAD_PFX_IND 8'h92

// ****************************************
// opcode column (high nibble) per addressing form
// ****************************************
`define OAD_COL_BTJ 4'h0
`define OAD_COL_BIT 4'h1
`define OAD_COL_REL 4'h2
`define OAD_COL_RMW_DIR 4'h3
`define OAD_COL_RMW_IDX_S 4'h6
`define OAD_COL_RMW_IDX_N 4'h7
`define OAD_COL_IMM 4'hA
`define OAD_COL_DIR_S 4'hB
`define OAD_COL_DIR_L 4'hC
`define OAD_COL_IDX_L 4'hD
`define OAD_COL_IDX_S 4'hE
`define OAD_COL_IDX_N 4'hF

// ****************************************
// address limits
// ****************************************
`define OAD_PAGE0_MAX 16'h00FF
`define OAD_IDX_SUM_MAX 16'h01FE

`endif

//--- shared/oad_pkg.sv
`default_nettype none

package oad_pkg;

  // ****************************************
  // addressing modes, one-hot
  // ****************************************
  typedef enum logic [16:0] {
    MODE_INH = 17'h00001, MODE_IMM = 17'h00002, MODE_DIR_S = 17'h00004,
    MODE_DIR_L = 17'h00008, MODE_IDX_N = 17'h00010, MODE_IDX_S = 17'h00020,
    MODE_IDX_L = 17'h00040, MODE_IND_S = 17'h00080, MODE_IND_L = 17'h00100,
    MODE_IIX_S = 17'h00200, MODE_IIX_L = 17'h00400, MODE_REL_D = 17'h00800,
    MODE_REL_I = 17'h01000, MODE_BIT_D = 17'h02000, MODE_BIT_I = 17'h04000,
    MODE_BTR_D = 17'h08000, MODE_BTR_I = 17'h10000
  } oad_mode_e;

  // decoder sequencing states
  typedef enum logic [3:0] {
    ST_OPC = 4'h1, ST_OPND = 4'h2, ST_PTR = 4'h4, ST_CALC = 4'h8
  } oad_state_e;

  // pointer reader states
  typedef enum logic [2:0] {
    P_IDLE = 3'h1, P_HI = 3'h2, P_LO = 3'h4
  } oad_ptr_e;

  // decoded instruction attributes
  typedef struct packed {
    oad_mode_e mode;
    logic use_y;
    logic rmw;
    logic bad;
    logic ptr_word;
    logic need_ptr;
    logic [1:0] nops;
  } oad_dec_s;

endpackage

`default_nettype wire

//--- shared/oad_ptr_if.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// pointer fetch request and answer
// ****************************************
interface oad_ptr_if;
  logic start;
  logic [7:0] addr;
  logic word;
  logic done;
  logic [15:0] value;
  modport req (output start, output addr, output word, input done, input value);
  modport rsp (input start, input addr, input word, output done, output value);
endinterface

`default_nettype wire

//--- src/oad_ea_adder.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// effective address and branch target sums
// ****************************************
module oad_ea_adder (
  // address operands
  input wire logic [15:0] i_base,
  input wire logic [7:0] i_index,
  input wire logic i_add_index,
  // branch operands
  input wire logic [15:0] i_pc,
  input wire logic [7:0] i_rel,
  // sums
  output logic [15:0] o_ea,
  output logic [15:0] o_target
);

  // unsigned index add, zero-extended so no page wrap
  assign o_ea = i_base + (i_add_index ? {8'h00, i_index} : 16'h0000);
  // signed 8-bit offset onto the pc
  assign o_target = i_pc + {{8{i_rel[7]}}, i_rel};

endmodule

`default_nettype wire

//--- src/oad_ptr_reader.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// page-zero pointer fetch, byte or word
// ****************************************
module oad_ptr_reader (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // request side
  oad_ptr_if.rsp pif,
  // memory read port
  output logic o_mem_rd,
  output logic [15:0] o_mem_addr,
  input wire logic i_mem_ack,
  input wire logic [7:0] i_mem_data
);

  oad_pkg::oad_ptr_e state;

  // read held until acknowledged
  assign o_mem_rd = (state != oad_pkg::P_IDLE);

  // sequence: high byte at pointer, low byte at pointer+1
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= oad_pkg::P_IDLE;
    end else if (state == oad_pkg::P_IDLE && pif.start) begin
      state <= pif.word ? oad_pkg::P_HI : oad_pkg::P_LO;
    end else if (state == oad_pkg::P_HI && i_mem_ack) begin
      state <= oad_pkg::P_LO;
    end else if (state == oad_pkg::P_LO && i_mem_ack) begin
      state <= oad_pkg::P_IDLE;
    end
  end

  // read address
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mem_addr <= 16'h0000;
    end else if (state == oad_pkg::P_IDLE && pif.start) begin
      o_mem_addr <= {8'h00, pif.addr};
    end else if (state == oad_pkg::P_HI && i_mem_ack) begin
      o_mem_addr <= o_mem_addr + 16'h0001;
    end
  end

  // pointer value and completion pulse
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pif.value <= 16'h0000;
      pif.done <= 1'b0;
    end else begin
      pif.done <= (state == oad_pkg::P_LO) && i_mem_ack;
      if (state == oad_pkg::P_IDLE && pif.start) begin
        pif.value <= 16'h0000;
      end else if (state == oad_pkg::P_HI && i_mem_ack) begin
        pif.value[15:8] <= i_mem_data;
      end else if (state == oad_pkg::P_LO && i_mem_ack) begin
        pif.value[7:0] <= i_mem_data;
      end
    end
  end

  ptr_order_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state == oad_pkg::P_HI && i_mem_ack) |=> (o_mem_addr == $past(o_mem_addr) + 16'h0001))
    else $error("pointer low byte not read from next address");

  byte_ptr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (pif.done && !pif.word) |-> (pif.value[15:8] == 8'h00))
    else $error("byte pointer has nonzero high byte");

endmodule

`default_nettype wire

//--- src/oad_operand_decoder.sv
`timescale 1ns/10ps
`default_nettype none
`include "oad_defs.svh"

module oad_operand_decoder (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // instruction byte stream
  input wire logic i_fetch_valid,
  input wire logic [7:0] i_fetch_byte,
  output logic o_fetch_ready,
  // core registers
  input wire logic [7:0] i_index_x,
  input wire logic [7:0] i_index_y,
  input wire logic [15:0] i_pc,
  // memory read port
  output logic o_mem_rd,
  output logic [15:0] o_mem_addr,
  input wire logic i_mem_ack,
  input wire logic [7:0] i_mem_data,
  // decoded result
  output logic o_done,
  output logic [7:0] o_opcode,
  output var oad_pkg::oad_mode_e o_mode,
  output logic o_use_y,
  output logic o_rmw,
  output logic o_bad_prefix,
  output logic [7:0] o_imm,
  output logic [15:0] o_ea,
  output logic [15:0] o_target,
  output logic [2:0] o_length
);

  // ****************************************
  // opcode and prefix decode
  // ****************************************
  function automatic oad_pkg::oad_dec_s decode(input logic [7:0] pfx, input logic [7:0] opc);
    oad_pkg::oad_dec_s d;
    logic ind;
    d = '{mode: oad_pkg::MODE_INH, default: '0};
    ind = (pfx == `OAD_PFX_IND) || (pfx == `OAD_PFX_IDY);
    case (opc[7:4])
      `OAD_COL_BTJ: begin
        d.mode = ind ? oad_pkg::MODE_BTR_I : oad_pkg::MODE_BTR_D;
        d.rmw = 1'b1;
        d.nops = 2'd2;
      end
      `OAD_COL_BIT: begin
        d.mode = ind ? oad_pkg::MODE_BIT_I : oad_pkg::MODE_BIT_D;
        d.rmw = 1'b1;
        d.nops = 2'd1;
      end
      `OAD_COL_REL: begin
        d.mode = ind ? oad_pkg::MODE_REL_I : oad_pkg::MODE_REL_D;
        d.nops = 2'd1;
      end
      `OAD_COL_RMW_DIR: begin
        d.mode = ind ? oad_pkg::MODE_IND_S : oad_pkg::MODE_DIR_S;
        d.rmw = 1'b1;
        d.nops = 2'd1;
      end
      `OAD_COL_RMW_IDX_S: begin
        d.mode = ind ? oad_pkg::MODE_IIX_S : oad_pkg::MODE_IDX_S;
        d.rmw = 1'b1;
        d.nops = 2'd1;
      end
      `OAD_COL_RMW_IDX_N: begin
        d.mode = oad_pkg::MODE_IDX_N;
        d.rmw = 1'b1;
      end
      `OAD_COL_IMM: begin
        d.mode = oad_pkg::MODE_IMM;
        d.nops = 2'd1;
      end
      `OAD_COL_DIR_S: begin
        d.mode = ind ? oad_pkg::MODE_IND_S : oad_pkg::MODE_DIR_S;
        d.nops = 2'd1;
      end
      `OAD_COL_DIR_L: begin
        d.mode = ind ? oad_pkg::MODE_IND_L : oad_pkg::MODE_DIR_L;
        d.nops = ind ? 2'd1 : 2'd2;
      end
      `OAD_COL_IDX_L: begin
        d.mode = ind ? oad_pkg::MODE_IIX_L : oad_pkg::MODE_IDX_L;
        d.nops = ind ? 2'd1 : 2'd2;
      end
      `OAD_COL_IDX_S: begin
        d.mode = ind ? oad_pkg::MODE_IIX_S : oad_pkg::MODE_IDX_S;
        d.nops = 2'd1;
      end
      `OAD_COL_IDX_N: begin
        d.mode = oad_pkg::MODE_IDX_N;
      end
      default: begin
        d.mode = oad_pkg::MODE_INH;
      end
    endcase
    d.ptr_word = d.mode inside {oad_pkg::MODE_IND_L, oad_pkg::MODE_IIX_L};
    d.need_ptr = d.mode inside {oad_pkg::MODE_IND_S, oad_pkg::MODE_IND_L, oad_pkg::MODE_IIX_S,
                                oad_pkg::MODE_IIX_L, oad_pkg::MODE_REL_I, oad_pkg::MODE_BIT_I,
                                oad_pkg::MODE_BTR_I};
    if (pfx == `OAD_PFX_Y) begin
      d.use_y = d.mode inside {oad_pkg::MODE_IMM, oad_pkg::MODE_DIR_S, oad_pkg::MODE_DIR_L,
                               oad_pkg::MODE_IDX_N, oad_pkg::MODE_IDX_S, oad_pkg::MODE_IDX_L,
                               oad_pkg::MODE_INH};
      d.bad = !d.use_y;
    end else if (pfx == `OAD_PFX_IDY) begin
      d.use_y = 1'b1;
      d.bad = !(d.mode inside {oad_pkg::MODE_IIX_S, oad_pkg::MODE_IIX_L});
    end else if (pfx == `OAD_PFX_IND) begin
      d.bad = !d.need_ptr;
    end
    return d;
  endfunction

  // ****************************************
  // reset release
  // ****************************************
  logic rst_meta;
  logic rst_sync;

  // two-stage release of the asynchronous reset
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // ****************************************
  // sequencing
  // ****************************************
  oad_pkg::oad_state_e state;
  oad_pkg::oad_dec_s dec;
  oad_pkg::oad_dec_s next_dec;
  logic [7:0] pfx;
  logic pfx_seen;
  logic [7:0] ops [0:1];
  logic [1:0] cnt;
  logic take;
  logic is_pfx;
  logic last_op;
  logic [15:0] ptr_val;
  logic [7:0] idx_sel;
  logic [15:0] base;
  logic [7:0] rel;
  logic add_idx;
  logic [15:0] ea_sum;
  logic [15:0] tgt_sum;

  oad_ptr_if pif ();

  // stream stalls outside opcode and operand collection
  assign o_fetch_ready = (state == oad_pkg::ST_OPC) || (state == oad_pkg::ST_OPND);
  assign take = i_fetch_valid && o_fetch_ready;
  assign is_pfx = !pfx_seen && (i_fetch_byte inside {`OAD_PFX_Y, `OAD_PFX_IDY, `OAD_PFX_IND});
  assign next_dec = decode(pfx_seen ? pfx : 8'h00, i_fetch_byte);
  assign last_op = ({1'b0, cnt} + 3'd1) == {1'b0, dec.nops};
  assign idx_sel = dec.use_y ? i_index_y : i_index_x;

  // state transitions
  always_ff @(posedge i_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      state <= oad_pkg::ST_OPC;
    end else begin
      case (state)
        oad_pkg::ST_OPC: begin
          if (take && !is_pfx) begin
            state <= (next_dec.nops == 2'd0) ? oad_pkg::ST_CALC : oad_pkg::ST_OPND;
          end
        end
        oad_pkg::ST_OPND: begin
          if (take && last_op) begin
            state <= dec.need_ptr ? oad_pkg::ST_PTR : oad_pkg::ST_CALC;
          end
        end
        oad_pkg::ST_PTR: begin
          if (pif.done) begin
            state <= oad_pkg::ST_CALC;
          end
        end
        default: begin
          state <= oad_pkg::ST_OPC;
        end
      endcase
    end
  end

  // prefix capture, cleared once the instruction completes
  always_ff @(posedge i_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      pfx <= 8'h00;
      pfx_seen <= 1'b0;
    end else if (state == oad_pkg::ST_OPC && take && is_pfx) begin
      pfx <= i_fetch_byte;
      pfx_seen <= 1'b1;
    end else if (state == oad_pkg::ST_CALC) begin
      pfx <= 8'h00;
      pfx_seen <= 1'b0;
    end
  end

  // opcode and its decode
  always_ff @(posedge i_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      dec <= '{mode: oad_pkg::MODE_INH, default: '0};
      o_opcode <= 8'h00;
    end else if (state == oad_pkg::ST_OPC && take && !is_pfx) begin
      dec <= next_dec;
      o_opcode <= i_fetch_byte;
    end
  end

  // operand byte counter
  always_ff @(posedge i_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      cnt <= 2'd0;
    end else if (state == oad_pkg::ST_OPC) begin
      cnt <= 2'd0;
    end else if (state == oad_pkg::ST_OPND && take) begin
      cnt <= cnt + 2'd1;
    end
  end

  // operand bytes in fetch order, first is the high byte of a word
  for (genvar g = 0; g < 2; g++) begin : g_ops
    always_ff @(posedge i_clk or negedge rst_sync) begin
      if (!rst_sync) begin
        ops[g] <= 8'h00;
      end else if (state == oad_pkg::ST_OPND && take && cnt == 2'(g)) begin
        ops[g] <= i_fetch_byte;
      end
    end
  end

  // pointer fetch request, one pulse on entry
  always_ff @(posedge i_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      pif.start <= 1'b0;
      pif.addr <= 8'h00;
      pif.word <= 1'b0;
    end else begin
      pif.start <= (state == oad_pkg::ST_OPND) && take && last_op && dec.need_ptr;
      pif.addr <= (cnt == 2'd0) ? i_fetch_byte : ops[0];
      pif.word <= dec.ptr_word;
    end
  end

  // fetched pointer value
  always_ff @(posedge i_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      ptr_val <= 16'h0000;
    end else if (pif.done) begin
      ptr_val <= pif.value;
    end
  end

  oad_ptr_reader u_ptr (
    .i_clk(i_clk),
    .i_rst_n(rst_sync),
    .pif(pif.rsp),
    .o_mem_rd(o_mem_rd),
    .o_mem_addr(o_mem_addr),
    .i_mem_ack(i_mem_ack),
    .i_mem_data(i_mem_data)
  );

  // ****************************************
  // address formation
  // ****************************************
  // base, index use and branch offset per mode
  always_comb begin
    base = {8'h00, ops[0]};
    add_idx = 1'b0;
    rel = ops[0];
    case (dec.mode)
      oad_pkg::MODE_DIR_L: base = {ops[0], ops[1]};
      oad_pkg::MODE_IDX_N: begin
        base = 16'h0000;
        add_idx = 1'b1;
      end
      oad_pkg::MODE_IDX_S: add_idx = 1'b1;
      oad_pkg::MODE_IDX_L: begin
        base = {ops[0], ops[1]};
        add_idx = 1'b1;
      end
      oad_pkg::MODE_IND_S, oad_pkg::MODE_IND_L, oad_pkg::MODE_BIT_I: base = ptr_val;
      oad_pkg::MODE_IIX_S, oad_pkg::MODE_IIX_L: begin
        base = ptr_val;
        add_idx = 1'b1;
      end
      oad_pkg::MODE_REL_I: rel = ptr_val[7:0];
      oad_pkg::MODE_BTR_D: rel = ops[1];
      oad_pkg::MODE_BTR_I: begin
        base = ptr_val;
        rel = ops[1];
      end
      default: base = {8'h00, ops[0]};
    endcase
  end

  oad_ea_adder u_add (
    .i_base(base),
    .i_index(idx_sel),
    .i_add_index(add_idx),
    .i_pc(i_pc),
    .i_rel(rel),
    .o_ea(ea_sum),
    .o_target(tgt_sum)
  );

  // ****************************************
  // result registers
  // ****************************************
  // results latched at the calculation step, done pulses once
  always_ff @(posedge i_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      o_done <= 1'b0;
      o_mode <= oad_pkg::MODE_INH;
      o_use_y <= 1'b0;
      o_rmw <= 1'b0;
      o_bad_prefix <= 1'b0;
      o_imm <= 8'h00;
      o_ea <= 16'h0000;
      o_target <= 16'h0000;
      o_length <= 3'd0;
    end else begin
      o_done <= (state == oad_pkg::ST_CALC);
      if (state == oad_pkg::ST_CALC) begin
        o_mode <= dec.mode;
        o_use_y <= dec.use_y;
        o_rmw <= dec.rmw;
        o_bad_prefix <= dec.bad;
        o_imm <= ops[0];
        o_ea <= ea_sum;
        o_target <= tgt_sum;
        o_length <= {2'b00, pfx_seen} + 3'd1 + {1'b0, dec.nops};
      end
    end
  end

  mode_onehot_a: assert property (@(posedge i_clk) disable iff (!rst_sync)
    o_done |-> $onehot(o_mode))
    else $error("mode not one-hot");

  inh_len_a: assert property (@(posedge i_clk) disable iff (!rst_sync)
    (o_done && o_mode == oad_pkg::MODE_INH) |-> (o_length == ((o_use_y || o_bad_prefix) ? 3'd2 : 3'd1)))
    else $error("inherent instruction length wrong");

  page_zero_a: assert property (@(posedge i_clk) disable iff (!rst_sync)
    (o_done && (o_mode inside {oad_pkg::MODE_DIR_S, oad_pkg::MODE_IND_S, oad_pkg::MODE_BIT_D,
     oad_pkg::MODE_BIT_I, oad_pkg::MODE_BTR_D, oad_pkg::MODE_BTR_I})) |-> (o_ea <= `OAD_PAGE0_MAX))
    else $error("short form left page zero");

  idx_none_a: assert property (@(posedge i_clk) disable iff (!rst_sync)
    (o_done && o_mode == oad_pkg::MODE_IDX_N) |->
      (o_ea == {8'h00, o_use_y ? $past(i_index_y) : $past(i_index_x)}))
    else $error("no-offset indexed address not index register");

  idx_short_a: assert property (@(posedge i_clk) disable iff (!rst_sync)
    (o_done && (o_mode inside {oad_pkg::MODE_IDX_S, oad_pkg::MODE_IIX_S})) |-> (o_ea <= `OAD_IDX_SUM_MAX))
    else $error("short indexed sum out of range");

  rmw_short_a: assert property (@(posedge i_clk) disable iff (!rst_sync)
    (o_done && o_rmw) |-> !(o_mode inside {oad_pkg::MODE_DIR_L, oad_pkg::MODE_IDX_L,
                                           oad_pkg::MODE_IND_L, oad_pkg::MODE_IIX_L}))
    else $error("read-modify-write took a long form");

  ptr_stall_a: assert property (@(posedge i_clk) disable iff (!rst_sync)
    (state == oad_pkg::ST_PTR) |-> (!o_fetch_ready && !o_done))
    else $error("stream accepted during pointer fetch");

  rel_target_a: assert property (@(posedge i_clk) disable iff (!rst_sync)
    (o_done && o_mode == oad_pkg::MODE_REL_D) |-> (o_target == $past(i_pc) + {{8{o_imm[7]}}, o_imm}))
    else $error("relative target wrong");

  done_pulse_a: assert property (@(posedge i_clk) disable iff (!rst_sync)
    o_done |=> !o_done ##1 (state != oad_pkg::ST_CALC || $past(take)))
    else $error("done longer than one cycle");

endmodule

`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  // ****************************************
  // bench signals
  // ****************************************
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic fv = 1'b0;
  logic [7:0] fb = 8'h00;
  logic [7:0] ix = 8'h00;
  logic [7:0] iy = 8'h00;
  logic [15:0] pc = 16'h0000;
  logic ack = 1'b0;
  logic [7:0] md = 8'h00;
  logic rdy, rd, done, use_y, rmw, bad;
  logic [15:0] maddr, ea, tgt;
  logic [7:0] opc, imm;
  logic [2:0] len;
  oad_pkg::oad_mode_e mode;
  logic [7:0] mem [256];
  int num_errors = 0;
  int num_checks = 0;

  // decoder under test
  oad_operand_decoder dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_fetch_valid(fv), .i_fetch_byte(fb), .o_fetch_ready(rdy),
    .i_index_x(ix), .i_index_y(iy), .i_pc(pc), .o_mem_rd(rd), .o_mem_addr(maddr),
    .i_mem_ack(ack), .i_mem_data(md), .o_done(done), .o_opcode(opc), .o_mode(mode),
    .o_use_y(use_y), .o_rmw(rmw), .o_bad_prefix(bad), .o_imm(imm), .o_ea(ea),
    .o_target(tgt), .o_length(len)
  );

  // 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end

  // ****************************************
  // common tasks
  // ****************************************
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR t=%0t seen=%0h exp=%0h", $time, s, e);
    end
  endtask

  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // pointer memory: ack one cycle after request, data scrambled when idle
  always @(posedge clk) begin
    if (rd === 1'b1 && ack === 1'b0) begin
      ack <= 1'b1;
      md <= mem[maddr[7:0]];
      chk(maddr[15:8], 8'h00);
    end else begin
      ack <= 1'b0;
      md <= ~md;
    end
  end

  // one byte, held until taken
  task automatic send(input logic [7:0] b);
    int n;
    n = 0;
    fv <= 1'b1;
    fb <= b;
    @(posedge clk);
    while (rdy !== 1'b1) begin
      n++;
      if (n > 40) begin
        num_errors++;
        report_and_stop();
      end
      @(posedge clk);
    end
  endtask

  // whole instruction, then wait for the result and compare
  task automatic ins(input logic [31:0] bs, input int n, input oad_pkg::oad_mode_e m,
                     input logic [15:0] e, input bit ce, input logic [2:0] l);
    int k;
    for (k = 0; k < n; k++) begin
      send(bs[31-8*k -: 8]);
    end
    fv <= 1'b0;
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
      if (k > 40) begin
        num_errors++;
        report_and_stop();
      end
    end while (done !== 1'b1);
    chk(mode, m);
    chk(len, l);
    if (ce) begin
      chk(ea, e);
    end
    @(posedge clk);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_plain();
    ins(32'h40000000, 1, oad_pkg::MODE_INH, 16'h0000, 0, 3'h1);
    ins(32'hA6550000, 2, oad_pkg::MODE_IMM, 16'h0000, 0, 3'h2);
    chk(imm, 8'h55);
    ins(32'hB6800000, 2, oad_pkg::MODE_DIR_S, 16'h0080, 1, 3'h2);
    chk(rmw, 1'b0);
    ins(32'h3A400000, 2, oad_pkg::MODE_DIR_S, 16'h0040, 1, 3'h2);
    chk(rmw, 1'b1);
    ins(32'hC6123400, 3, oad_pkg::MODE_DIR_L, 16'h1234, 1, 3'h3);
  endtask

  task automatic t_index();
    ix <= 8'hFF;
    ins(32'hF6000000, 1, oad_pkg::MODE_IDX_N, 16'h00FF, 1, 3'h1);
    ins(32'hE6FF0000, 2, oad_pkg::MODE_IDX_S, 16'h01FE, 1, 3'h2);
    ins(32'hD6FF0000, 3, oad_pkg::MODE_IDX_L, 16'hFFFF, 1, 3'h3);
    ins(32'h7A000000, 1, oad_pkg::MODE_IDX_N, 16'h00FF, 1, 3'h1);
    chk(rmw, 1'b1);
  endtask

  task automatic t_second_index();
    iy <= 8'h33;
    ins(32'h90F60000, 2, oad_pkg::MODE_IDX_N, 16'h0033, 1, 3'h2);
    chk(use_y, 1'b1);
    chk(opc, 8'hF6);
    ins(32'h90E61000, 3, oad_pkg::MODE_IDX_S, 16'h0043, 1, 3'h3);
    ins(32'h90200200, 3, oad_pkg::MODE_REL_D, 16'h0000, 0, 3'h3);
    chk(bad, 1'b1);
    ins(32'h90400000, 2, oad_pkg::MODE_INH, 16'h0000, 0, 3'h2);
    chk(use_y, 1'b1);
    chk(bad, 1'b0);
  endtask

  task automatic t_indirect();
    ix <= 8'hFF;
    iy <= 8'h01;
    ins(32'h92B62000, 3, oad_pkg::MODE_IND_S, 16'h005A, 1, 3'h3);
    ins(32'h92C63000, 3, oad_pkg::MODE_IND_L, 16'hABCD, 1, 3'h3);
    ins(32'h92E64000, 3, oad_pkg::MODE_IIX_S, 16'h01FE, 1, 3'h3);
    ins(32'h92D63000, 3, oad_pkg::MODE_IIX_L, 16'hACCC, 1, 3'h3);
    ins(32'h91E64000, 3, oad_pkg::MODE_IIX_S, 16'h0100, 1, 3'h3);
    chk(use_y, 1'b1);
    ins(32'h92A65500, 3, oad_pkg::MODE_IMM, 16'h0000, 0, 3'h3);
    chk(bad, 1'b1);
    ins(32'h92400000, 2, oad_pkg::MODE_INH, 16'h0000, 0, 3'h2);
    chk(bad, 1'b1);
    chk(use_y, 1'b0);
  endtask

  task automatic t_branch();
    pc <= 16'h1000;
    ins(32'h20FE0000, 2, oad_pkg::MODE_REL_D, 16'h0000, 0, 3'h2);
    chk(tgt, 16'h0FFE);
    ins(32'h92205000, 3, oad_pkg::MODE_REL_I, 16'h0000, 0, 3'h3);
    chk(tgt, 16'h107F);
    ins(32'h10800000, 2, oad_pkg::MODE_BIT_D, 16'h0080, 1, 3'h2);
    chk(rmw, 1'b1);
    ins(32'h92102000, 3, oad_pkg::MODE_BIT_I, 16'h005A, 1, 3'h3);
    ins(32'h00800500, 3, oad_pkg::MODE_BTR_D, 16'h0080, 1, 3'h3);
    chk(tgt, 16'h1005);
    ins(32'h920020FB, 4, oad_pkg::MODE_BTR_I, 16'h005A, 1, 3'h4);
    chk(tgt, 16'h0FFB);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    for (int k = 0; k < 256; k++) begin
      mem[k] = 8'(k) ^ 8'hA5;
    end
    mem[8'h20] = 8'h5A;
    mem[8'h30] = 8'hAB;
    mem[8'h31] = 8'hCD;
    mem[8'h40] = 8'hFF;
    mem[8'h50] = 8'h7F;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_plain();
    t_index();
    t_second_index();
    t_indirect();
    t_branch();
    report_and_stop();
  end
endmodule

`default_nettype wire
